// ---- spco_pkg.sv ----
package spco_pkg;
  // register byte offsets
  localparam logic [7:0] CTRL1_OFS = 8'h00;
  localparam logic [7:0] DATA_OFS = 8'h04;
  localparam logic [7:0] STS_OFS = 8'h08;
  localparam logic [7:0] WAKE_ID_OFS = 8'h0c;
  localparam logic [7:0] IRQ_STS_OFS = 8'h10;
  localparam logic [7:0] IRQ_CLR_OFS = 8'h14;
  localparam logic [7:0] IRQ_EN_OFS = 8'h18;
  // control register field positions
  localparam int PORT_ON_BIT = 13;
  localparam int WORD9_BIT = 12;
  localparam int WAKE_BIT = 11;
  localparam int PAR_ON_BIT = 10;
  localparam int PAR_ODD_BIT = 9;
  localparam int PARITY_ERR_FLAG_IE_BIT = 8;
  localparam int TXE_IE_BIT = 7;
  localparam int MUTE_BIT = 1;
  // status register field positions
  localparam int PARITY_ERR_FLAG_FLAG_BIT = 0;
  localparam int TXE_FLAG_BIT = 7;
  // interrupt status/clear/enable layout
  localparam int IRQ_PARITY_ERR_FLAG = 0;
  localparam int IRQ_TXE = 1;
  // reset values
  localparam logic TXE_RST = 1'h1;
  localparam logic [1:0] IRQ_EN_RST = 2'h0;
  localparam logic [3:0] WAKE_ID_RST = 4'h0;
  // frame sizes in data bits
  localparam logic [3:0] WLEN8 = 4'h8;
  localparam logic [3:0] WLEN9 = 4'h9;
  // timing
  localparam int CLK_HZ = 10_000_000;
  localparam int BAUD_DEFAULT = 625_000;

  typedef struct packed {
    logic port_on;
    logic word9;
    logic wake_id_mode;
    logic parity_on;
    logic parity_odd;
    logic parity_err_flag_ie;
    logic txe_ie;
    logic mute;
  } spco_ctrl_t;

  localparam spco_ctrl_t CTRL_RST = '{default: 1'b0};

  typedef enum logic [1:0] {
    TX_IDLE = 2'b01,
    TX_SHIFT = 2'b10
  } spco_tx_t;

  typedef enum logic [3:0] {
    RX_IDLE = 4'b0001,
    RX_START = 4'b0010,
    RX_DATA = 4'b0100,
    RX_STOP = 4'b1000
  } spco_rx_t;
endpackage

// ---- spco_top.sv ----
`timescale 1ns/1ps
// Contract
// [RULE_01] control bits 31 to 14 always read zero whatever is written
// [RULE_02] port enable at bit 13 resets off; software turns it on and off
// [RULE_03] bit 12 selects eight or nine data bits in both directions
// [RULE_04] bit 11 selects mute wake by idle line or by identifier match
// [RULE_05] bit 10 turns parity generation on; off means no parity handling
// [RULE_06] with parity on, the outgoing word's top bit becomes parity
// [RULE_07] with parity on, every received frame's parity bit is checked; frames received while muted are not checked
// [RULE_08] bit 9 picks even or odd parity for generation and checking
// [RULE_09] bits 8 and 7 enable parity error and transmit empty interrupts
// [RULE_10] a received parity mismatch sets the parity error flag
// [RULE_11] transmit empty sets on move to shifter, clears on data write
// [RULE_12] mute clears on the wake event; identifier mismatch sets it again
// [RULE_13] interrupt request while an enabled flag is set; code uses latched status bits, which need both enable sets
module spco_top #(
  parameter int BAUD = spco_pkg::BAUD_DEFAULT
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic rxd,
  output logic txd,
  output logic irq
);
  localparam int BIT_CLKS = spco_pkg::CLK_HZ / BAUD;
  localparam logic [15:0] BIT_LAST = 16'(BIT_CLKS - 1);
  localparam logic [15:0] HALF_LAST = 16'(BIT_CLKS / 2 - 1);

  // top data bit gets parity; the rest is covered by it
  function automatic logic [8:0] spco_fix(input logic [8:0] w, input spco_pkg::spco_ctrl_t c);
    logic [8:0] r;
    r = c.word9 ? w : {1'b0, w[7:0]};
    // [RULE_05] parity generation gate
    if (c.parity_on) begin
      // [RULE_08] odd flips the sense
      if (c.word9) begin
        r[8] = (^w[7:0]) ^ c.parity_odd;
      end else begin
        r[7] = (^w[6:0]) ^ c.parity_odd;
      end
    end
    return r;
  endfunction

  spco_pkg::spco_ctrl_t ctrl, next_ctrl;
  logic [3:0] wake_id, next_wake_id;
  logic [8:0] tx_buf, next_tx_buf;
  logic tx_full, next_tx_full;
  logic tx_empty_flag, next_tx_empty_flag;
  logic parity_err_flag, next_parity_err_flag;
  logic [8:0] rx_data, next_rx_data;
  logic [1:0] irq_sts, next_irq_sts;
  logic [1:0] irq_en, next_irq_en;
  logic [31:0] next_prdata;
  logic next_pready, next_pslverr, next_irq;

  spco_pkg::spco_tx_t tx_state, next_tx_state;
  logic [9:0] tx_sh, next_tx_sh;
  logic [3:0] tx_bits, next_tx_bits;
  logic [15:0] tx_cnt, next_tx_cnt;
  logic next_txd;
  logic rx_s1, rx_s2;
  spco_pkg::spco_rx_t rx_state, next_rx_state;
  logic [8:0] rx_sh, next_rx_sh;
  logic [3:0] rx_bits, next_rx_bits;
  logic [15:0] rx_cnt, next_rx_cnt;
  logic [15:0] idle_cnt, next_idle_cnt;
  logic tx_take, rx_done, idle_hit;
  logic [3:0] nbits;
  logic [15:0] idle_len;
  logic [8:0] tx_fixed;

  // line engine: transmit shifter, receive sampler, idle detector
  always_comb begin
    next_tx_state = tx_state;
    next_tx_sh = tx_sh;
    next_tx_bits = tx_bits;
    next_tx_cnt = tx_cnt;
    next_txd = txd;
    next_rx_state = rx_state;
    next_rx_sh = rx_sh;
    next_rx_bits = rx_bits;
    next_rx_cnt = rx_cnt;
    next_idle_cnt = idle_cnt;
    tx_take = 1'b0;
    rx_done = 1'b0;
    idle_hit = 1'b0;
    // [RULE_03] frame length
    nbits = ctrl.word9 ? spco_pkg::WLEN9 : spco_pkg::WLEN8;
    // a function result cannot be part-selected, so it is held here first
    tx_fixed = spco_fix(tx_buf, ctrl);
    idle_len = 16'((32'(nbits) + 2) * BIT_CLKS);
    unique case (tx_state)
      spco_pkg::TX_IDLE: begin
        next_txd = 1'b1;
        if (ctrl.port_on && tx_full) begin
          // [RULE_06] parity replaces top bit
          next_tx_sh = ctrl.word9 ? {1'b1, tx_fixed} : {2'b11, tx_fixed[7:0]};
          tx_take = 1'b1;
          next_txd = 1'b0;
          next_tx_bits = nbits + 4'h1;
          next_tx_cnt = BIT_LAST;
          next_tx_state = spco_pkg::TX_SHIFT;
        end
      end
      spco_pkg::TX_SHIFT: begin
        if (!ctrl.port_on) begin
          // disabling aborts the frame mid-flight
          next_txd = 1'b1;
          next_tx_state = spco_pkg::TX_IDLE;
        end else if (tx_cnt != 16'h0) begin
          next_tx_cnt = tx_cnt - 16'h1;
        end else if (tx_bits == 4'h0) begin
          next_tx_state = spco_pkg::TX_IDLE;
        end else begin
          next_txd = tx_sh[0];
          next_tx_sh = {1'b1, tx_sh[9:1]};
          next_tx_bits = tx_bits - 4'h1;
          next_tx_cnt = BIT_LAST;
        end
      end
    endcase
    unique case (rx_state)
      spco_pkg::RX_IDLE: begin
        if (ctrl.port_on && !rx_s2) begin
          next_rx_cnt = HALF_LAST;
          next_rx_state = spco_pkg::RX_START;
        end
      end
      spco_pkg::RX_START: begin
        if (rx_cnt != 16'h0) begin
          next_rx_cnt = rx_cnt - 16'h1;
        end else if (rx_s2) begin
          // glitch, not a start bit
          next_rx_state = spco_pkg::RX_IDLE;
        end else begin
          next_rx_cnt = BIT_LAST;
          next_rx_bits = nbits;
          next_rx_state = spco_pkg::RX_DATA;
        end
      end
      spco_pkg::RX_DATA: begin
        if (rx_cnt != 16'h0) begin
          next_rx_cnt = rx_cnt - 16'h1;
        end else begin
          next_rx_sh = {rx_s2, rx_sh[8:1]};
          next_rx_bits = rx_bits - 4'h1;
          next_rx_cnt = BIT_LAST;
          if (rx_bits == 4'h1) begin
            next_rx_state = spco_pkg::RX_STOP;
          end
        end
      end
      spco_pkg::RX_STOP: begin
        if (rx_cnt != 16'h0) begin
          next_rx_cnt = rx_cnt - 16'h1;
        end else begin
          rx_done = 1'b1;
          next_rx_state = spco_pkg::RX_IDLE;
        end
      end
    endcase
    if (!ctrl.port_on) begin
      next_rx_state = spco_pkg::RX_IDLE;
    end
    // idle line: high for one whole frame; fires once per high stretch
    if (!rx_s2 || rx_state != spco_pkg::RX_IDLE) begin
      next_idle_cnt = 16'h0;
    end else if (idle_cnt != idle_len) begin
      next_idle_cnt = idle_cnt + 16'h1;
      idle_hit = (idle_cnt == idle_len - 16'h1) && ctrl.port_on;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_state <= spco_pkg::TX_IDLE;
      tx_sh <= 10'h3ff;
      tx_bits <= 4'h0;
      tx_cnt <= 16'h0;
      txd <= 1'b1;
      rx_s1 <= 1'b1;
      rx_s2 <= 1'b1;
      rx_state <= spco_pkg::RX_IDLE;
      rx_sh <= 9'h0;
      rx_bits <= 4'h0;
      rx_cnt <= 16'h0;
      idle_cnt <= 16'h0;
    end else if (ce) begin
      tx_state <= next_tx_state;
      tx_sh <= next_tx_sh;
      tx_bits <= next_tx_bits;
      tx_cnt <= next_tx_cnt;
      txd <= next_txd;
      rx_s1 <= rxd;
      rx_s2 <= rx_s1;
      rx_state <= next_rx_state;
      rx_sh <= next_rx_sh;
      rx_bits <= next_rx_bits;
      rx_cnt <= next_rx_cnt;
      idle_cnt <= next_idle_cnt;
    end
  end

  logic setup, wr;
  logic [8:0] rx_word;
  logic addr_frame;

  // register file, bus answer, flags and interrupt
  always_comb begin
    next_ctrl = ctrl;
    next_wake_id = wake_id;
    next_tx_buf = tx_buf;
    next_tx_full = tx_full;
    next_tx_empty_flag = tx_empty_flag;
    next_parity_err_flag = parity_err_flag;
    next_rx_data = rx_data;
    next_irq_sts = irq_sts;
    next_irq_en = irq_en;
    next_prdata = 32'h0;
    // answer any selected cycle not yet answered; a setup met while frozen is not lost
    setup = psel && !pready;
    wr = psel && penable && pready && pwrite;
    next_pready = setup;
    next_pslverr = 1'b0;
    rx_word = ctrl.word9 ? rx_sh : {1'b0, rx_sh[8:1]};
    addr_frame = ctrl.word9 ? rx_word[8] : rx_word[7];
    if (setup && !pwrite) begin
      unique case (paddr)
        spco_pkg::CTRL1_OFS: begin
          // [RULE_01] upper bits read zero
          next_prdata[spco_pkg::PORT_ON_BIT] = ctrl.port_on;
          next_prdata[spco_pkg::WORD9_BIT] = ctrl.word9;
          next_prdata[spco_pkg::WAKE_BIT] = ctrl.wake_id_mode;
          next_prdata[spco_pkg::PAR_ON_BIT] = ctrl.parity_on;
          next_prdata[spco_pkg::PAR_ODD_BIT] = ctrl.parity_odd;
          next_prdata[spco_pkg::PARITY_ERR_FLAG_IE_BIT] = ctrl.parity_err_flag_ie;
          next_prdata[spco_pkg::TXE_IE_BIT] = ctrl.txe_ie;
          next_prdata[spco_pkg::MUTE_BIT] = ctrl.mute;
        end
        spco_pkg::DATA_OFS: next_prdata[8:0] = rx_data;
        spco_pkg::STS_OFS: begin
          next_prdata[spco_pkg::PARITY_ERR_FLAG_FLAG_BIT] = parity_err_flag;
          next_prdata[spco_pkg::TXE_FLAG_BIT] = tx_empty_flag;
        end
        spco_pkg::WAKE_ID_OFS: next_prdata[3:0] = wake_id;
        spco_pkg::IRQ_STS_OFS: next_prdata[1:0] = irq_sts;
        spco_pkg::IRQ_EN_OFS: next_prdata[1:0] = irq_en;
        spco_pkg::IRQ_CLR_OFS: next_prdata = 32'h0;
        default: next_pslverr = 1'b1;
      endcase
    end else if (setup) begin
      next_pslverr = !(paddr inside {spco_pkg::CTRL1_OFS, spco_pkg::DATA_OFS,
                                     spco_pkg::WAKE_ID_OFS, spco_pkg::IRQ_CLR_OFS,
                                     spco_pkg::IRQ_EN_OFS});
    end
    // hardware take first, so a software write in the same cycle refills
    if (tx_take) begin
      next_tx_full = 1'b0;
      // [RULE_11] set on move to shifter
      next_tx_empty_flag = 1'b1;
    end
    if (wr) begin
      unique case (paddr)
        spco_pkg::CTRL1_OFS: begin
          // [RULE_02] port enable and mode bits
          next_ctrl.port_on = pwdata[spco_pkg::PORT_ON_BIT];
          next_ctrl.word9 = pwdata[spco_pkg::WORD9_BIT];
          next_ctrl.wake_id_mode = pwdata[spco_pkg::WAKE_BIT];
          next_ctrl.parity_on = pwdata[spco_pkg::PAR_ON_BIT];
          next_ctrl.parity_odd = pwdata[spco_pkg::PAR_ODD_BIT];
          // [RULE_09] interrupt enables
          next_ctrl.parity_err_flag_ie = pwdata[spco_pkg::PARITY_ERR_FLAG_IE_BIT];
          next_ctrl.txe_ie = pwdata[spco_pkg::TXE_IE_BIT];
          next_ctrl.mute = pwdata[spco_pkg::MUTE_BIT];
        end
        spco_pkg::DATA_OFS: begin
          next_tx_buf = pwdata[8:0];
          next_tx_full = 1'b1;
          // [RULE_11] cleared by data write
          next_tx_empty_flag = 1'b0;
        end
        spco_pkg::WAKE_ID_OFS: next_wake_id = pwdata[3:0];
        spco_pkg::IRQ_CLR_OFS: begin
          next_irq_sts = irq_sts & ~pwdata[1:0];
          if (pwdata[spco_pkg::IRQ_PARITY_ERR_FLAG]) begin
            next_parity_err_flag = 1'b0;
          end
        end
        spco_pkg::IRQ_EN_OFS: next_irq_en = pwdata[1:0];
        default: ;
      endcase
    end
    // hardware events land after software clears, so sets win
    if (tx_take) begin
      next_irq_sts[spco_pkg::IRQ_TXE] = 1'b1;
    end
    // [RULE_12] idle wake
    if (idle_hit && ctrl.mute && !ctrl.wake_id_mode) begin
      next_ctrl.mute = 1'b0;
    end
    if (rx_done) begin
      if (ctrl.wake_id_mode && addr_frame) begin
        // [RULE_04] identifier decides mute
        next_ctrl.mute = (rx_word[3:0] != wake_id);
      end
      if (!ctrl.mute) begin
        next_rx_data = rx_word;
        // [RULE_07] compare against regenerated parity
        if (ctrl.parity_on && spco_fix(rx_word, ctrl) != rx_word) begin
          // [RULE_10] mismatch sets flag
          next_parity_err_flag = 1'b1;
          next_irq_sts[spco_pkg::IRQ_PARITY_ERR_FLAG] = 1'b1;
        end
      end
    end
    // [RULE_13] gated by both enable sets
    next_irq = |(next_irq_sts & next_irq_en & {next_ctrl.txe_ie, next_ctrl.parity_err_flag_ie});
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= spco_pkg::CTRL_RST;
      wake_id <= spco_pkg::WAKE_ID_RST;
      tx_buf <= 9'h0;
      tx_full <= 1'b0;
      tx_empty_flag <= spco_pkg::TXE_RST;
      parity_err_flag <= 1'b0;
      rx_data <= 9'h0;
      irq_sts <= 2'h0;
      irq_en <= spco_pkg::IRQ_EN_RST;
      prdata <= 32'h0;
      pready <= 1'b0;
      pslverr <= 1'b0;
      irq <= 1'b0;
    end else if (ce) begin
      ctrl <= next_ctrl;
      wake_id <= next_wake_id;
      tx_buf <= next_tx_buf;
      tx_full <= next_tx_full;
      tx_empty_flag <= next_tx_empty_flag;
      parity_err_flag <= next_parity_err_flag;
      rx_data <= next_rx_data;
      irq_sts <= next_irq_sts;
      irq_en <= next_irq_en;
      prdata <= next_prdata;
      pready <= next_pready;
      pslverr <= next_pslverr;
      irq <= next_irq;
    end
  end
endmodule

// ---- spco_top_assertions.sv ----
`timescale 1ns/1ps
module spco_top_assertions #(
  parameter int BAUD = spco_pkg::BAUD_DEFAULT
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic rxd,
  input wire logic txd,
  input wire logic irq
);
  logic [13:7] sh;
  logic [13:7] next_sh;
  logic wr_ctrl;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // mirror of the software-owned control bits; mute is left out as hardware moves it
  assign wr_ctrl = psel && penable && pready && pwrite && paddr == spco_pkg::CTRL1_OFS;
  always_comb begin
    next_sh = sh;
    if (wr_ctrl && ce) begin
      next_sh = pwdata[13:7];
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sh <= '0;
    end else begin
      sh <= next_sh;
    end
  end
  sequence s_setup;
    psel && !penable && ce;
  endsequence
  sequence s_rd_ctrl;
    pready && !pwrite && paddr == spco_pkg::CTRL1_OFS;
  endsequence
  a_ready_after_setup: assert property (s_setup |=> pready)
    else $error("no ready after setup");
  a_ready_pulse: assert property (pready && ce |=> !pready)
    else $error("ready held too long");
  a_slverr_pair: assert property (pslverr |-> pready)
    else $error("error without ready");
  a_prdata_quiet: assert property (!(pready && !pwrite) |-> prdata == 32'h0)
    else $error("read data outside a read");
  a_reserved_zero: assert property (s_rd_ctrl |-> prdata[31:14] == 18'h0)
    else $error("reserved control bits not zero");
  a_ctrl_readback: assert property (s_rd_ctrl |-> prdata[13:7] == sh)
    else $error("control bits lost");
  a_port_off_idle: assert property (!sh[13] [*3] |-> txd)
    else $error("line active while port off");
  // irq and the enables are registered on the same edge, so compare current values
  a_irq_cause: assert property (irq |-> (sh[8] || sh[7]))
    else $error("interrupt with no enable");
  a_ce_freeze: assert property (!ce |=> $stable(pready) && $stable(pslverr) && $stable(prdata)
    && $stable(txd) && $stable(irq))
    else $error("outputs moved while clock enable low");
endmodule
bind spco_top spco_top_assertions #(.BAUD(BAUD)) i_spco_top_assertions (
  .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .rxd(rxd), .txd(txd), .irq(irq));

// ---- spco_remote.sv ----
`timescale 1ns/1ps
module spco_remote #(
  parameter int BT = 4
) (
  input wire logic pclk,
  input wire logic txd,
  input wire logic [3:0] nbits,
  // line rests high between frames
  output logic rxd = 1'b1,
  output logic [8:0] rx_word = 9'h0,
  output logic rx_got = 1'b0
);
  logic [8:0] w;
  // one frame towards the block, lsb first, start low, stop high
  task automatic send(input logic [8:0] v, input int n);
    for (int i = -1; i <= n; i++) begin
      rxd <= i < 0 ? 1'b0 : i == n ? 1'b1 : v[i];
      repeat (BT) @(posedge pclk);
    end
  endtask
  // mid-bit sampling; the stop bit is not checked, so a short stop goes unseen
  always begin
    @(negedge txd);
    w = 9'h0;
    repeat (BT / 2) @(posedge pclk);
    for (int i = 0; i < nbits; i++) begin
      repeat (BT) @(posedge pclk);
      w[i] = txd;
    end
    repeat (BT) @(posedge pclk);
    rx_word <= w;
    rx_got <= 1'b1;
    @(posedge pclk);
    rx_got <= 1'b0;
  end
endmodule

// ---- tb.sv ----
`timescale 1ns/1ps
module tb;
  logic pclk = 1'b0, presetn = 1'b0, ce = 1'b1;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, rxd, txd, irq, rx_got;
  logic [8:0] rx_word;
  logic [3:0] nbits = 4'h8;
  logic [32:0] rd_q[$];
  logic [32:0] tx_q[$];
  int mismatches = 0;
  int total_checks = 0;
  // 10 MHz clock
  always #50 pclk = ~pclk;
  spco_top #(.BAUD(2_500_000)) i_spco_top (.pclk(pclk), .presetn(presetn), .ce(ce),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .rxd(rxd), .txd(txd), .irq(irq));
  spco_remote #(.BT(4)) i_spco_remote (.pclk(pclk), .txd(txd), .nbits(nbits), .rxd(rxd),
    .rx_word(rx_word), .rx_got(rx_got));
  task automatic chk(input string nm, input logic [32:0] seen, input logic [32:0] exp);
    total_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // a wait that used up its bound ends the run
  task automatic late(input int n);
    if (n >= 2000) begin
      mismatches++;
      test_done();
    end
  endtask
  // one transfer; a read notes its expected {pslverr, prdata}
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
    input logic [32:0] e);
    int n;
    n = 0;
    if (!wr) rd_q.push_back(e);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 2000);
    late(n);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  // each answer against the oldest note
  always @(posedge pclk) begin
    if (psel && penable && pready && !pwrite && rd_q.size() > 0) begin
      chk("read", {pslverr, prdata}, rd_q.pop_front());
    end
    if (rx_got === 1'b1 && tx_q.size() > 0) begin
      chk("frame", {24'h0, rx_word}, tx_q.pop_front());
    end
  end
  initial begin
    logic [8:0] d;
    logic [8:0] e;
    logic [31:0] c;
    int n;
    n = $urandom(48);
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    // reset values, reserved bits, refused address
    apb(1'b0, spco_pkg::CTRL1_OFS, 32'h0, 33'h0);
    apb(1'b0, spco_pkg::STS_OFS, 32'h0, 33'h80);
    apb(1'b1, spco_pkg::CTRL1_OFS, 32'hffffffff, 33'h0);
    apb(1'b0, spco_pkg::CTRL1_OFS, 32'h0, 33'h3f82);
    apb(1'b0, 8'hfc, 32'h0, {1'b1, 32'h0});
    apb(1'b1, spco_pkg::IRQ_EN_OFS, 32'h3, 33'h0);
    // a read held while frozen must be answered only once the enable returns
    ce <= 1'b0;
    fork
      apb(1'b0, spco_pkg::IRQ_EN_OFS, 32'h0, 33'h3);
      begin
        repeat (6) @(posedge pclk);
        ce <= 1'b1;
      end
    join
    // every word length with parity off, even and odd
    for (int i = 0; i < 8; i++) begin
      c = {18'h0, 1'b1, i[0], 1'b0, i[1], i[2], 2'b01, 7'h0};
      nbits <= i[0] ? 4'h9 : 4'h8;
      apb(1'b1, spco_pkg::CTRL1_OFS, c, 33'h0);
      d = 9'($urandom()) & (i[0] ? 9'h1ff : 9'h0ff);
      e = d;
      if (i[1] && i[0]) e[8] = ^d[7:0] ^ i[2];
      if (i[1] && !i[0]) e[7] = ^d[6:0] ^ i[2];
      tx_q.push_back({24'h0, e});
      apb(1'b1, spco_pkg::DATA_OFS, {23'h0, d}, 33'h0);
      n = 0;
      while (tx_q.size() > 0 && n < 2000) begin
        @(posedge pclk);
        n++;
      end
      late(n);
    end
    chk("irq", {32'h0, irq}, 33'h1);
    apb(1'b0, spco_pkg::IRQ_STS_OFS, 32'h0, 33'h2);
    apb(1'b1, spco_pkg::IRQ_CLR_OFS, 32'h3, 33'h0);
    apb(1'b0, spco_pkg::STS_OFS, 32'h0, 33'h80);
    chk("irq", {32'h0, irq}, 33'h0);
    // frame 0x83: good under odd, bad and masked, bad and enabled
    nbits <= 4'h8;
    for (int j = 0; j < 3; j++) begin
      c = {18'h0, 3'b100, 1'b1, j == 0, j != 1, 8'h0};
      apb(1'b1, spco_pkg::CTRL1_OFS, c, 33'h0);
      i_spco_remote.send(9'h083, 8);
      n = 0;
      while (irq !== 1'b1 && n < 40) begin
        @(posedge pclk);
        n++;
      end
      chk("parity_err_flag irq", {32'h0, irq}, {32'h0, j == 2});
      apb(1'b0, spco_pkg::STS_OFS, 32'h0, {25'h0, 1'b1, 6'h0, j != 0});
      apb(1'b0, spco_pkg::DATA_OFS, 32'h0, 33'h083);
      apb(1'b1, spco_pkg::IRQ_CLR_OFS, 32'h1, 33'h0);
    end
    // identifier wake: mismatch stays muted, match wakes, mismatch mutes again
    apb(1'b1, spco_pkg::WAKE_ID_OFS, 32'h5, 33'h0);
    apb(1'b1, spco_pkg::CTRL1_OFS, 32'h2802, 33'h0);
    for (int k = 0; k < 3; k++) begin
      i_spco_remote.send(k == 1 ? 9'h085 : 9'h086, 8);
      repeat (8) @(posedge pclk);
      apb(1'b0, spco_pkg::CTRL1_OFS, 32'h0, {31'ha00, k != 1, 1'b0});
    end
    // idle wake after a frame and a quiet line
    apb(1'b1, spco_pkg::CTRL1_OFS, 32'h2002, 33'h0);
    i_spco_remote.send(9'h011, 8);
    repeat (60) @(posedge pclk);
    apb(1'b0, spco_pkg::CTRL1_OFS, 32'h0, 33'h2000);
    // port off keeps the word buffered, so the data write's clear stays visible
    apb(1'b1, spco_pkg::CTRL1_OFS, 32'h0, 33'h0);
    apb(1'b1, spco_pkg::DATA_OFS, 32'h0a5, 33'h0);
    apb(1'b0, spco_pkg::STS_OFS, 32'h0, 33'h0);
    test_done();
  end
endmodule
